//--- pkg/crcpad_pkg.sv
// package for the checksum padding register bank
// assumes a 32-bit apb slave with one register per aligned word
`default_nettype none

package crcpad_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_PAD_DD = 8'hdd;
	localparam logic [7:0] IDX_PAD_DE = 8'hde;
	localparam logic [7:0] IDX_PAD_DF = 8'hdf;
	localparam logic [7:0] IDX_PAD_E0 = 8'he0;
	localparam logic [7:0] IDX_PAD_E1 = 8'he1;
	localparam logic [7:0] IDX_PAD_E2 = 8'he2;
	localparam logic [7:0] IDX_CHECKSUM = 8'hfe;
	localparam logic [7:0] IDX_CALC = 8'hf0;
	localparam logic [7:0] IDX_STATUS = 8'hf1;

	////////////////////////////////////////////////////////////////////////////
	// writable bit masks; bits outside a mask read their fixed value
	localparam logic [15:0] WMASK_DD = 16'he01f;
	localparam logic [15:0] WMASK_DE = 16'he01f;
	localparam logic [15:0] WMASK_DF = 16'he01f;
	localparam logic [15:0] WMASK_E0 = 16'h0c30;
	localparam logic [15:0] WMASK_E1 = 16'hffff;
	localparam logic [15:0] WMASK_E2 = 16'hff00;
	localparam logic [15:0] WMASK_CHECKSUM = 16'hffff;

	// fixed reserved patterns
	localparam logic [15:0] FIXED_DD = 16'h0000;
	localparam logic [15:0] FIXED_DE = 16'h0000;
	localparam logic [15:0] FIXED_DF = 16'h0000;
	localparam logic [15:0] FIXED_E0 = 16'h0200;
	localparam logic [15:0] FIXED_E1 = 16'h0000;
	localparam logic [15:0] FIXED_E2 = 16'h0000;

	// reset values of whole registers
	localparam logic [15:0] RST_DD = 16'h000d;
	localparam logic [15:0] RST_DE = 16'h000e;
	localparam logic [15:0] RST_DF = 16'h000f;
	localparam logic [15:0] RST_E0 = 16'h0210;
	localparam logic [15:0] RST_E1 = 16'h0000;
	localparam logic [15:0] RST_E2 = 16'h0000;
	localparam logic [15:0] RST_CHECKSUM = 16'h0000;

	////////////////////////////////////////////////////////////////////////////
	// status fields and checksum engine constants
	localparam int STAT_MATCH_BIT = 0;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam int PAD_WORDS = 6;

endpackage : crcpad_pkg

`default_nettype wire

//--- design/crcpad_crc16.sv
// checksum engine over the padding words, msb first
// assumes the words are stable or change only by register writes
`default_nettype none

module crcpad_crc16
	import crcpad_pkg::*;
#(
	parameter int WORDS = PAD_WORDS
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [16*WORDS-1:0] pad_words,
	output logic [15:0] crc_value
);

	////////////////////////////////////////////////////////////////////////////
	// elaboration check
	if (WORDS < 1)
	begin : g_bad_words
		$error("crcpad_crc16: WORDS must be at least one");
	end

	// bitwise crc over the whole vector, first word in the top bits
	function automatic logic [15:0] crc_of(input logic [16*WORDS-1:0] data);
		logic [15:0] c;
		logic fb;
		c = CRC_INIT;
		fb = 1'b0;
		for (int i = 16*WORDS-1; i >= 0; i--)
		begin
			fb = c[15] ^ data[i];
			c = {c[14:0], 1'b0};
			if (fb)
			begin
				c = c ^ CRC_POLY;
			end
		end
		return c;
	endfunction : crc_of

	////////////////////////////////////////////////////////////////////////////
	// registered result, one cycle behind the words
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			crc_value <= 16'h0000;
		end
		else
		begin
			crc_value <= crc_of(pad_words);
		end
	end

endmodule : crcpad_crc16

`default_nettype wire

//--- design/crcpad_bank.sv
// padding register bank with section three checksum register, apb slave
// assumes apb4 master on pclk, zero wait states, presetn asynchronous
//
// Our own choice: the APB slave port.
`default_nettype none

module crcpad_bank
	import crcpad_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic section_three_checksum_ok
);

	////////////////////////////////////////////////////////////////////////////
	// elaboration check: index fe needs ten address bits
	if (ADDR_W < 10)
	begin : g_bad_addr
		$error("crcpad_bank: ADDR_W must be at least ten");
	end

	// true when the word address selects the given index
	function automatic logic hits(
		input logic [ADDR_W-1:0] a,
		input logic [7:0] idx
	);
		return (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
	endfunction : hits

	// merge write data under byte strobes and writable mask
	function automatic logic [15:0] merge(
		input logic [15:0] old,
		input logic [15:0] wd,
		input logic [1:0] strb,
		input logic [15:0] wmask
	);
		logic [15:0] m;
		m = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
		return (wd & m) | (old & ~m);
	endfunction : merge

	////////////////////////////////////////////////////////////////////////////
	// storage
	logic [15:0] crc_pad_dd;
	logic [15:0] crc_pad_de;
	logic [15:0] crc_pad_df;
	logic [15:0] crc_pad_e0;
	logic [15:0] crc_pad_e1;
	logic [15:0] crc_pad_e2;
	logic [15:0] section_three_checksum_value;
	logic [15:0] calc_crc;

	// bus phase decode
	wire logic setup_phase = psel && !penable;
	wire logic access_wr = psel && penable && pwrite;
	wire logic [15:0] wd16 = pwdata[15:0];
	wire logic [1:0] strb2 = pstrb[1:0];

	// address decode
	wire logic sel_dd = hits(paddr, IDX_PAD_DD);
	wire logic sel_de = hits(paddr, IDX_PAD_DE);
	wire logic sel_df = hits(paddr, IDX_PAD_DF);
	wire logic sel_e0 = hits(paddr, IDX_PAD_E0);
	wire logic sel_e1 = hits(paddr, IDX_PAD_E1);
	wire logic sel_e2 = hits(paddr, IDX_PAD_E2);
	wire logic sel_cs = hits(paddr, IDX_CHECKSUM);
	wire logic sel_calc = hits(paddr, IDX_CALC);
	wire logic sel_stat = hits(paddr, IDX_STATUS);
	wire logic mapped = sel_dd | sel_de | sel_df | sel_e0 | sel_e1 | sel_e2
		| sel_cs | sel_calc | sel_stat;

	// zero wait state slave
	assign pready = 1'b1;

	////////////////////////////////////////////////////////////////////////////
	// pad dd: filler in 15:13 and 4:0, zeros in 12:5
	wire logic wr_dd = access_wr && sel_dd;
	wire logic [15:0] next_pad_dd = merge(crc_pad_dd, wd16, strb2, WMASK_DD);
	wire logic [15:0] view_dd = (crc_pad_dd & WMASK_DD) | FIXED_DD;

	// dd storage, loaded only on the access edge of a write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			crc_pad_dd <= RST_DD;
		end
		else if (wr_dd)
		begin
			crc_pad_dd <= next_pad_dd;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pad de: filler in 15:13 and 4:0, zeros in 12:5
	wire logic wr_de = access_wr && sel_de;
	wire logic [15:0] next_pad_de = merge(crc_pad_de, wd16, strb2, WMASK_DE);
	wire logic [15:0] view_de = (crc_pad_de & WMASK_DE) | FIXED_DE;

	// de storage, loaded only on the access edge of a write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			crc_pad_de <= RST_DE;
		end
		else if (wr_de)
		begin
			crc_pad_de <= next_pad_de;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pad df: filler in 15:13 and 4:0, zeros in 12:5
	wire logic wr_df = access_wr && sel_df;
	wire logic [15:0] next_pad_df = merge(crc_pad_df, wd16, strb2, WMASK_DF);
	wire logic [15:0] view_df = (crc_pad_df & WMASK_DF) | FIXED_DF;

	// df storage, loaded only on the access edge of a write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			crc_pad_df <= RST_DF;
		end
		else if (wr_df)
		begin
			crc_pad_df <= next_pad_df;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pad e0: filler in 11:10 and 5:4, fixed 1000b in 9:6
	wire logic wr_e0 = access_wr && sel_e0;
	wire logic [15:0] next_pad_e0 = merge(crc_pad_e0, wd16, strb2, WMASK_E0);
	wire logic [15:0] view_e0 = (crc_pad_e0 & WMASK_E0) | FIXED_E0;

	// e0 storage; the fixed bits kept here are masked off on read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			crc_pad_e0 <= RST_E0;
		end
		else if (wr_e0)
		begin
			crc_pad_e0 <= next_pad_e0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pad e1: filler across all sixteen bits
	wire logic wr_e1 = access_wr && sel_e1;
	wire logic [15:0] next_pad_e1 = merge(crc_pad_e1, wd16, strb2, WMASK_E1);
	wire logic [15:0] view_e1 = (crc_pad_e1 & WMASK_E1) | FIXED_E1;

	// e1 storage, loaded only on the access edge of a write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			crc_pad_e1 <= RST_E1;
		end
		else if (wr_e1)
		begin
			crc_pad_e1 <= next_pad_e1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pad e2: filler in the upper byte, lower byte reads zero
	wire logic wr_e2 = access_wr && sel_e2;
	wire logic [15:0] next_pad_e2 = merge(crc_pad_e2, wd16, strb2, WMASK_E2);
	wire logic [15:0] view_e2 = (crc_pad_e2 & WMASK_E2) | FIXED_E2;

	// e2 storage, loaded only on the access edge of a write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			crc_pad_e2 <= RST_E2;
		end
		else if (wr_e2)
		begin
			crc_pad_e2 <= next_pad_e2;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checksum value at fe: all sixteen bits writable
	wire logic wr_cs = access_wr && sel_cs;
	wire logic [15:0] next_checksum =
		merge(section_three_checksum_value, wd16, strb2, WMASK_CHECKSUM);

	// stored checksum; only compared with the engine, steers nothing else
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			section_three_checksum_value <= RST_CHECKSUM;
		end
		else if (wr_cs)
		begin
			section_three_checksum_value <= next_checksum;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checksum engine over the padding words only; they steer nothing else
	crcpad_crc16 #(
		.WORDS(PAD_WORDS)
	) i_crcpad_crc16 (
		.pclk(pclk),
		.presetn(presetn),
		.pad_words({view_dd, view_de, view_df, view_e0, view_e1, view_e2}),
		.crc_value(calc_crc)
	);

	// comparison of computed and stored checksum
	wire logic match_now = (calc_crc == section_three_checksum_value);
	wire logic [15:0] status_word = 16'(match_now) << STAT_MATCH_BIT;

	// read data selection
	wire logic [15:0] rd_word =
		sel_dd ? view_dd :
		sel_de ? view_de :
		sel_df ? view_df :
		sel_e0 ? view_e0 :
		sel_e1 ? view_e1 :
		sel_e2 ? view_e2 :
		sel_cs ? section_three_checksum_value :
		sel_calc ? calc_crc :
		sel_stat ? status_word : 16'h0000;

	////////////////////////////////////////////////////////////////////////////
	// read data captured in the setup cycle, held through access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
		end
		else if (setup_phase)
		begin
			prdata <= {16'h0000, rd_word};
		end
	end

	// error for unmapped or misaligned words, dropped once psel falls
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pslverr <= 1'b0;
		end
		else if (setup_phase)
		begin
			pslverr <= !mapped;
		end
		else if (!psel)
		begin
			pslverr <= 1'b0;
		end
	end

	// registered checksum agreement flag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			section_three_checksum_ok <= 1'b0;
		end
		else
		begin
			section_three_checksum_ok <= match_now;
		end
	end

endmodule : crcpad_bank

`default_nettype wire

//--- test/crcpad_bank_asserts.sv
// checker on the apb port of the padding register bank
// assumes pready tied high and paddr wider than nine bits
`default_nettype none
module crcpad_bank_chk
#(
	parameter int ADDR_W = 12
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic section_three_checksum_ok
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// read access phase and low address bits
	wire logic rd;
	wire logic [9:0] a;
	assign rd = psel && penable && !pwrite;
	assign a = paddr[9:0];
	////////////////////////////////////////
	ready_tie_a: assert property (pready) else $error("pready low");
	dd_fixed_a: assert property (rd && a == 10'h374 |-> prdata[12:5] == 8'h00)
		else $error("dd reserved bits");
	de_fixed_a: assert property (rd && a == 10'h378 |-> prdata[12:5] == 8'h00)
		else $error("de reserved bits");
	df_fixed_a: assert property (rd && a == 10'h37c |-> prdata[12:5] == 8'h00)
		else $error("df reserved bits");
	e0_fixed_a: assert property (rd && a == 10'h380 |-> prdata[15:12] == 4'h0 &&
		prdata[9:6] == 4'h8 && prdata[3:0] == 4'h0) else $error("e0 reserved bits");
	e2_low_a: assert property (rd && a == 10'h388 |-> prdata[7:0] == 8'h00)
		else $error("e2 low byte");
	upper_zero_a: assert property (rd |-> prdata[31:16] == 16'h0000)
		else $error("upper half not zero");
	wr_back_a: assert property (psel && penable && pwrite && a == 10'h384 &&
		pstrb == 4'h3 ##3 rd && a == 10'h384 |-> prdata[15:0] == $past(pwdata[15:0], 3))
		else $error("e1 readback");
	stat_copy_a: assert property (rd && paddr == ADDR_W'(10'h3c4) |->
		prdata[15:0] == {15'h0000, section_three_checksum_ok}) else $error("match flag copy");
	cs_mapped_a: assert property (psel && penable && paddr == ADDR_W'(10'h3f8)
		|-> !pslverr) else $error("checksum register refused");
endmodule : crcpad_bank_chk
bind crcpad_bank crcpad_bank_chk #(.ADDR_W(ADDR_W)) i_crcpad_bank_chk (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.pstrb(pstrb),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.section_three_checksum_ok(section_three_checksum_ok)
);
`default_nettype wire

//--- test/test_crcpad_bank.sv
// bench for the padding register bank over apb
// assumes the checker is bound to the design
`default_nettype none
module test_crcpad_bank;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, ok, errv;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rdv;
	logic [3:0] pstrb = 0;
	logic [15:0] cs;
	int err_total = 0, total_checks = 0;
	logic [11:0] ad [6] = '{12'h374, 12'h378, 12'h37c, 12'h380, 12'h384, 12'h388};
	logic [15:0] rv [6] = '{16'h000d, 16'h000e, 16'h000f, 16'h0210, 16'h0000, 16'h0000};
	logic [15:0] ov [6] = '{16'he01f, 16'he01f, 16'he01f, 16'h0e30, 16'hffff, 16'hff00};
	logic [15:0] zv [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0200, 16'h0000, 16'h0000};
	// clock at 40 ns
	always #20 pclk = ~pclk;
	crcpad_bank #(.ADDR_W(12)) i_crcpad_bank (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.section_three_checksum_ok(ok));
	////////////////////////////////////////
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer, held until pready is seen high or eight access cycles pass; if pready never came the test stops
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 8);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			$display("ERROR %0t: no pready in the access phase", $time);
			err_total++;
			stop_test();
		end
	endtask : xfer
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0, 4'h0);
		chk(rdv, exp);
	endtask : rd
	// reference checksum from the package polynomial and seed, msb first
	function automatic logic [15:0] crc_ref(input logic [95:0] d);
		logic [15:0] c;
		c = crcpad_pkg::CRC_INIT;
		for (int i = 95; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? crcpad_pkg::CRC_POLY : 16'h0000);
		return c;
	endfunction : crc_ref
	////////////////////////////////////////
	// main sequence
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++)
			rd(ad[i], {16'h0, rv[i]});
		rd(12'h3f8, 32'h0);
		$display("reset values done");
		for (int i = 0; i < 6; i++)
		begin
			xfer(1'b1, ad[i], 32'hffffffff, 4'hf);
			rd(ad[i], {16'h0, ov[i]});
			xfer(1'b1, ad[i], 32'h0, 4'hf);
			rd(ad[i], {16'h0, zv[i]});
		end
		$display("mask test done");
		xfer(1'b1, 12'h384, 32'h1234, 4'h3);
		rd(12'h384, 32'h1234);
		xfer(1'b1, 12'h384, 32'habcd, 4'h1);
		rd(12'h384, 32'h12cd);
		xfer(1'b1, 12'h3f8, 32'ha5c3, 4'h3);
		rd(12'h3f8, 32'ha5c3);
		xfer(1'b1, 12'h388, 32'ha5a5, 4'h2);
		rd(12'h388, 32'ha500);
		rd(12'h000, 32'h0);
		chk({31'h0, errv}, 32'h1);
		$display("data test done");
		xfer(1'b1, 12'h374, 32'hffff, 4'h3);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h374, 32'h000d);
		rd(12'h3f8, 32'h0);
		$display("second reset done");
		cs = crc_ref({rv[0], rv[1], rv[2], rv[3], rv[4], rv[5]});
		rd(12'h3c0, {16'h0, cs});
		chk({31'h0, ok}, {31'h0, cs == 16'h0000});
		xfer(1'b1, 12'h3f8, {16'h0, cs}, 4'h3);
		repeat (2) @(posedge pclk);
		chk({31'h0, ok}, 32'h1);
		rd(12'h3c4, 32'h1);
		xfer(1'b1, 12'h384, 32'h1, 4'h1);
		cs = crc_ref({rv[0], rv[1], rv[2], rv[3], 16'h0001, rv[5]});
		rd(12'h3c0, {16'h0, cs});
		rd(12'h3c4, 32'h0);
		chk({31'h0, ok}, 32'h0);
		$display("checksum test done");
		stop_test();
	end
endmodule : test_crcpad_bank
`default_nettype wire
